// [hw/nvmcc_defines.svh]
// nvm command controller: offsets, field positions, reset values, codes
// assumes inclusion by bare name from the design file
`ifndef NVMCC_DEFINES_SVH
`define NVMCC_DEFINES_SVH
`define NVMCC_OFS_CMD 4'h0
`define NVMCC_OFS_MAP 4'h1
`define NVMCC_OFS_STAT 4'h2
`define NVMCC_OFS_INTEN 4'h3
`define NVMCC_OFS_INTFL 4'h4
`define NVMCC_OFS_RSVD 4'h5
`define NVMCC_OFS_DATA_LO 4'h6
`define NVMCC_OFS_DATA_HI 4'h7
`define NVMCC_OFS_ADDR_0 4'h8
`define NVMCC_OFS_ADDR_1 4'h9
`define NVMCC_OFS_ADDR_2 4'ha
`define NVMCC_OFS_KEY 4'hf
`define NVMCC_RST_CMD 7'h00
`define NVMCC_RST_MAP 8'h30
`define NVMCC_MAP_LOCK_BIT 7
`define NVMCC_MAP_SEC_HI 5
`define NVMCC_MAP_SEC_LO 4
`define NVMCC_STAT_ERR_HI 6
`define NVMCC_STAT_ERR_LO 4
`define NVMCC_STAT_EEPROM_BUSY_FLAG_BIT 1
`define NVMCC_STAT_FLASH_BUSY_FLAG_BIT 0
`define NVMCC_CMD_NO_COMMAND_CODE 7'h00
`define NVMCC_CMD_NO_OPERATION_CODE 7'h01
`define NVMCC_CMD_FLASH_WRITE_ENABLE 7'h02
`define NVMCC_CMD_FLASH_SINGLE_PAGE_ERASE 7'h08
`define NVMCC_CMD_FLMPER_LAST 7'h0d
`define NVMCC_CMD_EEPROM_WRITE_ENABLE 7'h12
`define NVMCC_CMD_EEPROM_ERASE_WRITE_ENABLE 7'h13
`define NVMCC_CMD_EEPROM_BYTE_ERASE 7'h18
`define NVMCC_CMD_EEMBER_LAST 7'h1d
`define NVMCC_CMD_CHIP 7'h20
`define NVMCC_CMD_EEFULL 7'h30
`define NVMCC_KEY_PM 8'h9d
`define NVMCC_KEY_IO 8'hd8
`define NVMCC_KEY_WINDOW 3'h4
`define NVMCC_ERASE_ALL 8'hff
`endif

// [hw/nvmcc_pkg.sv]
// nvm command controller: shared types
// assumes nvmcc_defines.svh on the include path
`default_nettype none
package nvmcc_pkg;
  typedef enum logic [2:0] {
    NVMCC_ERR_NONE,
    NVMCC_ERR_BADCMD,
    NVMCC_ERR_WPROT,
    NVMCC_ERR_COLLIDE
  } nvmcc_err_e;
  typedef enum logic [2:0] {
    NVMCC_IDLE,
    NVMCC_FL_OP,
    NVMCC_EE_OP,
    NVMCC_CHIP_FL,
    NVMCC_CHIP_EE,
    NVMCC_EE_FULL
  } nvmcc_state_e;
endpackage : nvmcc_pkg
`default_nettype wire

// [hw/nvmcc_ctrl.sv]
// nvm command controller: command register, sequencer, status, ready irq
// assumes a memory array engine that answers each start with a done pulse
//
// How it works
// - chip erase wipes flash and eeprom, eeprom kept if keep fuse set
// - locked device: chip erase always wipes eeprom too
// - boot/app protection bits never block a chip erase
// - after chip erase all flash bytes, and eeprom bytes unless kept, read all ones
// - chip erase only accepted from the debug port
// - eeprom full erase wipes every eeprom byte to all ones
// - cpu bus stalled during the whole eeprom full erase
// - fuses untouched; fuse brown-out enable held during chip erase
// - reset aborts any write in progress
// - ready flag set whenever eeprom can take a new operation
// - irq high while enabled and flag set
// - controller sleeps only if system sleeps and nothing is busy
// - clocks stay on through sleep until the operation ends
// - ready irq wakes only from idle sleep
// - protected write without valid key is dropped
// - chip and eeprom full erase codes start at once; flash and eeprom codes arm, stores start them
// - command other than the 0x00 and 0x01 no-ops while busy reports collision
// - flash codes 0x02, 0x08, 0x09..0x0d
// - eeprom codes 0x12, 0x13, 0x18, 0x19..0x1d
// - chip erase 0x20, eeprom full erase 0x30, 0x00 and 0x01 no-ops, rest reserved
// - error field 0 none, 1 bad cmd, 2 protected, 3 collision
// - ready flag stays set while idle, write one clears
// - busy bits show eeprom and flash operations
// - collision blocks new operations until cleared
`include "nvmcc_defines.svh"
`default_nettype none
module nvmcc_ctrl
  import nvmcc_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic reg_from_debug,
  output logic [7:0] reg_rdata,
  // cpu stores to the arrays
  input wire logic store_req,
  input wire logic store_to_eeprom,
  input wire logic [23:0] store_addr,
  input wire logic [15:0] store_data,
  output logic cpu_stall,
  // memory array engine
  output logic op_start,
  output logic [6:0] op_code,
  output logic [23:0] op_addr,
  output logic [15:0] op_data,
  input wire logic op_done,
  input wire logic [15:0] load_data,
  input wire logic load_valid,
  // fuses and lock, static straps
  input wire logic keep_eeprom_fuse,
  input wire logic device_locked,
  input wire logic bod_fuse_en,
  output logic bod_keep_on,
  // sleep and interrupt
  input wire logic sys_sleep,
  input wire logic sleep_is_idle,
  output logic ctrl_asleep,
  output logic clk_keep_on,
  output logic wake_req,
  output logic irq
);
  logic [6:0] cmd_q;
  logic [7:0] map_q;
  logic [2:0] err_q;
  logic inten_q;
  logic rdy_flag_q;
  logic [15:0] data_q;
  logic [23:0] addr_q;
  logic [2:0] key_cnt_pm_q;
  logic [2:0] key_cnt_io_q;
  logic keep_q, lock_q, bod_q;
  nvmcc_state_e state_q;
  logic ee_busy, fl_busy, busy;
  logic wr_cmd, wr_map, cmd_ok, cmd_valid, arm_code, store_go;
  logic [6:0] wcmd;

  // straps are sampled twice, never read at the first stage
  logic keep_s, lock_s, bod_s;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      keep_s <= 1'b0;
      lock_s <= 1'b0;
      bod_s <= 1'b0;
      keep_q <= 1'b0;
      lock_q <= 1'b0;
      bod_q <= 1'b0;
    end else begin
      keep_s <= keep_eeprom_fuse;
      lock_s <= device_locked;
      bod_s <= bod_fuse_en;
      keep_q <= keep_s;
      lock_q <= lock_s;
      bod_q <= bod_s;
    end
  end

  assign ee_busy = (state_q == NVMCC_EE_OP) || (state_q == NVMCC_CHIP_EE)
    || (state_q == NVMCC_EE_FULL);
  assign fl_busy = (state_q == NVMCC_FL_OP) || (state_q == NVMCC_CHIP_FL);
  assign busy = ee_busy || fl_busy;
  assign wcmd = reg_wdata[6:0];
  assign wr_cmd = reg_wr && (reg_addr == `NVMCC_OFS_CMD)
    && (key_cnt_pm_q != 3'h0);
  assign wr_map = reg_wr && (reg_addr == `NVMCC_OFS_MAP)
    && (key_cnt_io_q != 3'h0);
  assign arm_code = (wcmd == `NVMCC_CMD_FLASH_WRITE_ENABLE)
    || (wcmd >= `NVMCC_CMD_FLASH_SINGLE_PAGE_ERASE && wcmd <= `NVMCC_CMD_FLMPER_LAST)
    || (wcmd == `NVMCC_CMD_EEPROM_WRITE_ENABLE) || (wcmd == `NVMCC_CMD_EEPROM_ERASE_WRITE_ENABLE)
    || (wcmd >= `NVMCC_CMD_EEPROM_BYTE_ERASE
      && wcmd <= `NVMCC_CMD_EEMBER_LAST);
  assign cmd_valid = arm_code || (wcmd == `NVMCC_CMD_NO_COMMAND_CODE)
    || (wcmd == `NVMCC_CMD_NO_OPERATION_CODE) || (wcmd == `NVMCC_CMD_EEFULL)
    || (wcmd == `NVMCC_CMD_CHIP && reg_from_debug);
  // collision: a real command while busy, or any op while error stands
  assign cmd_ok = wr_cmd && cmd_valid && !busy
    && (err_q != NVMCC_ERR_COLLIDE);
  assign store_go = store_req && !busy && (err_q != NVMCC_ERR_COLLIDE)
    && (cmd_q != `NVMCC_CMD_NO_COMMAND_CODE) && (cmd_q != `NVMCC_CMD_NO_OPERATION_CODE)
    && (cmd_q != `NVMCC_CMD_CHIP) && (cmd_q != `NVMCC_CMD_EEFULL)
    && (store_to_eeprom == (cmd_q[4] == 1'b1));

  // key window: counts stand for the four instructions after a key
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      key_cnt_pm_q <= 3'h0;
      key_cnt_io_q <= 3'h0;
    end else if (reg_wr && reg_addr == `NVMCC_OFS_KEY) begin
      key_cnt_pm_q <= (reg_wdata == `NVMCC_KEY_PM) ? `NVMCC_KEY_WINDOW : 3'h0;
      key_cnt_io_q <= (reg_wdata == `NVMCC_KEY_IO) ? `NVMCC_KEY_WINDOW : 3'h0;
    end else begin
      if (key_cnt_pm_q != 3'h0)
        key_cnt_pm_q <= key_cnt_pm_q - 3'h1;
      if (key_cnt_io_q != 3'h0) key_cnt_io_q <= key_cnt_io_q - 3'h1;
    end
  end

  // command register; a held chip or eeprom full erase code never arms a store
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cmd_q <= `NVMCC_RST_CMD;
    end else if (cmd_ok) begin
      cmd_q <= wcmd;
    end
  end

  // protection bits only settable, cleared by reset; lock freezes the section field
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      map_q <= `NVMCC_RST_MAP;
    end else if (wr_map) begin
      map_q[2:0] <= map_q[2:0] | reg_wdata[2:0];
      map_q[`NVMCC_MAP_LOCK_BIT] <= map_q[`NVMCC_MAP_LOCK_BIT]
        | reg_wdata[`NVMCC_MAP_LOCK_BIT];
      if (!map_q[`NVMCC_MAP_LOCK_BIT])
        map_q[`NVMCC_MAP_SEC_HI:`NVMCC_MAP_SEC_LO] <=
          reg_wdata[`NVMCC_MAP_SEC_HI:`NVMCC_MAP_SEC_LO];
    end
  end

  // sequencer; reset aborts whatever runs
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= NVMCC_IDLE;
      op_start <= 1'b0;
      op_code <= `NVMCC_CMD_NO_COMMAND_CODE;
      op_addr <= 24'h000000;
      op_data <= 16'h0000;
    end else begin
      op_start <= 1'b0;
      case (state_q)
        NVMCC_IDLE: begin
          if (cmd_ok && wcmd == `NVMCC_CMD_CHIP) begin
            // protection bits ignored on purpose
            state_q <= NVMCC_CHIP_FL;
            op_start <= 1'b1;
            op_code <= `NVMCC_CMD_CHIP;
            op_data <= {2{`NVMCC_ERASE_ALL}};
          end else if (cmd_ok && wcmd == `NVMCC_CMD_EEFULL) begin
            state_q <= NVMCC_EE_FULL;
            op_start <= 1'b1;
            op_code <= `NVMCC_CMD_EEFULL;
            op_data <= {2{`NVMCC_ERASE_ALL}};
          end else if (store_go) begin
            state_q <= store_to_eeprom ? NVMCC_EE_OP : NVMCC_FL_OP;
            op_start <= 1'b1;
            op_code <= cmd_q;
            op_addr <= store_addr;
            op_data <= store_data;
          end
        end
        NVMCC_CHIP_FL: begin
          if (op_done) begin
            if (lock_q || !keep_q) begin
              state_q <= NVMCC_CHIP_EE;
              op_start <= 1'b1;
              op_code <= `NVMCC_CMD_EEFULL;
            end else begin
              state_q <= NVMCC_IDLE;
            end
          end
        end
        NVMCC_FL_OP, NVMCC_EE_OP, NVMCC_CHIP_EE, NVMCC_EE_FULL: begin
          if (op_done) state_q <= NVMCC_IDLE;
        end
        default: state_q <= NVMCC_IDLE;
      endcase
    end
  end

  // error field; collision set wins over a software clear
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      err_q <= NVMCC_ERR_NONE;
    end else if (wr_cmd && busy && wcmd != `NVMCC_CMD_NO_COMMAND_CODE
        && wcmd != `NVMCC_CMD_NO_OPERATION_CODE) begin
      err_q <= NVMCC_ERR_COLLIDE;
    end else if (reg_wr && reg_addr == `NVMCC_OFS_STAT) begin
      err_q <= reg_wdata[`NVMCC_STAT_ERR_HI:`NVMCC_STAT_ERR_LO];
    end else if (err_q != NVMCC_ERR_COLLIDE && wr_cmd) begin
      err_q <= cmd_valid ? NVMCC_ERR_NONE : NVMCC_ERR_BADCMD;
    end else if (err_q != NVMCC_ERR_COLLIDE && store_go) begin
      err_q <= NVMCC_ERR_NONE;
    end
  end

  // interrupt enable and ready flag; hardware set wins over write-one
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      inten_q <= 1'b0;
      rdy_flag_q <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == `NVMCC_OFS_INTEN) inten_q <= reg_wdata[0];
      if (!ee_busy)
        rdy_flag_q <= 1'b1;
      else if (reg_wr && reg_addr == `NVMCC_OFS_INTFL && reg_wdata[0])
        rdy_flag_q <= 1'b0;
    end
  end

  // data and address registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      data_q <= 16'h0000;
      addr_q <= 24'h000000;
    end else begin
      if (load_valid) data_q <= load_data;
      else if (reg_wr && reg_addr == `NVMCC_OFS_DATA_LO)
        data_q[7:0] <= reg_wdata;
      else if (reg_wr && reg_addr == `NVMCC_OFS_DATA_HI)
        data_q[15:8] <= reg_wdata;
      if (store_go) addr_q <= store_addr;
      else if (reg_wr && reg_addr == `NVMCC_OFS_ADDR_0)
        addr_q[7:0] <= reg_wdata;
      else if (reg_wr && reg_addr == `NVMCC_OFS_ADDR_1)
        addr_q[15:8] <= reg_wdata;
      else if (reg_wr && reg_addr == `NVMCC_OFS_ADDR_2)
        addr_q[23:16] <= reg_wdata;
    end
  end

  // read port, data one cycle after the strobe
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `NVMCC_OFS_CMD: reg_rdata <= {1'b0, cmd_q};
        `NVMCC_OFS_MAP: reg_rdata <= map_q;
        `NVMCC_OFS_STAT:
          reg_rdata <= {1'b0, err_q, 2'b00, ee_busy, fl_busy};
        `NVMCC_OFS_INTEN: reg_rdata <= {7'h00, inten_q};
        `NVMCC_OFS_INTFL: reg_rdata <= {7'h00, rdy_flag_q};
        `NVMCC_OFS_DATA_LO: reg_rdata <= data_q[7:0];
        `NVMCC_OFS_DATA_HI: reg_rdata <= data_q[15:8];
        `NVMCC_OFS_ADDR_0: reg_rdata <= addr_q[7:0];
        `NVMCC_OFS_ADDR_1: reg_rdata <= addr_q[15:8];
        `NVMCC_OFS_ADDR_2: reg_rdata <= addr_q[23:16];
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // stall, irq, sleep; registered off state, so outputs lag it a cycle; full_d looks ahead for eeprom-full
  logic busy_d, full_d;
  assign busy_d = busy || op_start;
  assign full_d = (state_q == NVMCC_EE_FULL)
    || (cmd_ok && wcmd == `NVMCC_CMD_EEFULL);
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cpu_stall <= 1'b0;
      irq <= 1'b0;
      wake_req <= 1'b0;
      ctrl_asleep <= 1'b0;
      clk_keep_on <= 1'b0;
      bod_keep_on <= 1'b0;
    end else begin
      // chip erase flash half and eeprom-full halt the cpu; store on busy eeprom waits
      cpu_stall <= full_d || (state_q == NVMCC_CHIP_FL)
        || (store_req && ee_busy);
      irq <= inten_q && rdy_flag_q;
      wake_req <= inten_q && rdy_flag_q && sys_sleep
        && sleep_is_idle;
      ctrl_asleep <= sys_sleep && !busy_d;
      clk_keep_on <= busy_d;
      bod_keep_on <= bod_q && ((state_q == NVMCC_CHIP_FL)
        || (state_q == NVMCC_CHIP_EE));
    end
  end

  // checks
  irq_follows_flag_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (inten_q && rdy_flag_q) |=> irq) else $error("irq missing");
  ready_when_idle_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    !ee_busy |=> rdy_flag_q) else $error("ready flag not set");
  chip_cpu_refused_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (wr_cmd && !busy && wcmd == `NVMCC_CMD_CHIP && !reg_from_debug)
    |=> state_q != NVMCC_CHIP_FL) else $error("cpu started chip erase");
  collision_flag_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (wr_cmd && busy && wcmd > `NVMCC_CMD_NO_OPERATION_CODE)
    |=> err_q == NVMCC_ERR_COLLIDE) else $error("collision lost");
  // an erase already under way may still start its eeprom half
  collide_blocks_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (err_q == NVMCC_ERR_COLLIDE && state_q == NVMCC_IDLE) |=> !op_start)
    else $error("op during collision");
  eefull_stall_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (state_q == NVMCC_EE_FULL) |=> cpu_stall) else $error("no stall");
  unkeyed_cmd_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (reg_wr && reg_addr == `NVMCC_OFS_CMD && key_cnt_pm_q == 3'h0)
    |=> $stable(cmd_q)) else $error("unkeyed write took");
  chip_keeps_ee_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (state_q == NVMCC_CHIP_FL && op_done && keep_q && !lock_q)
    |=> state_q == NVMCC_IDLE) else $error("eeprom erased");
  locked_erase_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (state_q == NVMCC_CHIP_FL && op_done && lock_q)
    |=> state_q == NVMCC_CHIP_EE ##0 op_start) else $error("locked ee kept");
  sleep_busy_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    busy |=> !ctrl_asleep ##0 clk_keep_on) else $error("slept busy");
  rsvd_zero_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (reg_rd && reg_addr == `NVMCC_OFS_RSVD) |=> reg_rdata == 8'h00)
    else $error("reserved nonzero");
  wake_deep_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    !sleep_is_idle |=> !wake_req) else $error("wake from deep sleep");
  erase_ones_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (op_start && (op_code == `NVMCC_CMD_CHIP || op_code == `NVMCC_CMD_EEFULL))
    |-> op_data == {2{`NVMCC_ERASE_ALL}}) else $error("erase not all ones");
  bod_kept_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (bod_q && state_q == NVMCC_CHIP_FL) |=> bod_keep_on)
    else $error("brown-out dropped");
  chip_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
    state_q == NVMCC_CHIP_EE);
  eefull_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
    state_q == NVMCC_EE_FULL);
  collide_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
    err_q == NVMCC_ERR_COLLIDE);
  flash_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
    state_q == NVMCC_FL_OP);
  wake_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
    wake_req);
endmodule : nvmcc_ctrl
`default_nettype wire

// [sim/nvmcc_array_model.sv]
// array engine stand-in: answers each op_start with one op_done pulse
// assumes starts never overlap; lag sets how slowly the array answers
`default_nettype none
module nvmcc_array_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // from the controller, lag from the bench
  input wire logic op_start,
  input wire logic [7:0] lag,
  // answer
  output logic op_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_q;
  logic run_q;
  // reset drops a running operation, as the real array aborts it
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 8'h00;
      run_q <= 1'b0;
      op_done <= 1'b0;
    end else begin
      op_done <= 1'b0;
      if (op_start) begin
        run_q <= 1'b1;
        cnt_q <= lag;
      end else if (run_q && cnt_q == 8'h00) begin
        run_q <= 1'b0;
        op_done <= 1'b1;
      end else if (run_q) begin
        cnt_q <= cnt_q - 8'h01;
      end
    end
  end
endmodule : nvmcc_array_model
`default_nettype wire

// [sim/tb_nvm_command_controller.sv]
// bench for the nvm command controller: registers, commands, erases, sleep
// assumes nvmcc_array_model as the array; straps settle within 3 cycles
`default_nettype none
module tb_nvm_command_controller;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic reg_from_debug = 1'b0;
  logic store_req = 1'b0;
  logic store_to_eeprom = 1'b0;
  logic [23:0] store_addr = 24'h000000;
  logic [15:0] store_data = 16'h0000;
  logic keep_eeprom_fuse = 1'b0;
  logic device_locked = 1'b0;
  logic bod_fuse_en = 1'b1;
  logic sys_sleep = 1'b0;
  logic sleep_is_idle = 1'b0;
  logic [7:0] lag = 8'h04;
  logic [7:0] reg_rdata;
  logic [6:0] op_code;
  logic [23:0] op_addr;
  logic [15:0] op_data;
  logic cpu_stall, op_start, op_done, bod_keep_on;
  logic ctrl_asleep, clk_keep_on, wake_req, irq;
  logic [6:0] last_code;
  logic [23:0] last_addr;
  int n_mismatch = 0;
  int n_compared = 0;
  int n_starts = 0;
  int n_done = 0;
  // index in the top nibble, expected read value below
  logic [11:0] regs [12] = '{12'h000, 12'h130, 12'h200, 12'h300, 12'h401,
    12'h500, 12'h600, 12'h700, 12'h800, 12'h900, 12'ha00, 12'hc00};
  // bit 7 marks a code that must be refused
  logic [7:0] codes [22] = '{8'h02, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c,
    8'h0d, 8'h12, 8'h13, 8'h18, 8'h19, 8'h1a, 8'h1b, 8'h1c, 8'h1d, 8'h83,
    8'h8e, 8'h94, 8'h9e, 8'ha1, 8'hff, 8'ha0};
  // keep fuse, lock
  logic [1:0] chip [3] = '{2'b00, 2'b10, 2'b11};

  always #5 clk_sys = ~clk_sys;

  nvmcc_ctrl nvmcc_ctrl_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_from_debug(reg_from_debug), .reg_rdata(reg_rdata),
    .store_req(store_req), .store_to_eeprom(store_to_eeprom),
    .store_addr(store_addr), .store_data(store_data),
    .cpu_stall(cpu_stall), .op_start(op_start), .op_code(op_code),
    .op_addr(op_addr), .op_data(op_data), .op_done(op_done),
    .load_data(16'h0000), .load_valid(1'b0),
    .keep_eeprom_fuse(keep_eeprom_fuse), .device_locked(device_locked),
    .bod_fuse_en(bod_fuse_en), .bod_keep_on(bod_keep_on),
    .sys_sleep(sys_sleep), .sleep_is_idle(sleep_is_idle),
    .ctrl_asleep(ctrl_asleep), .clk_keep_on(clk_keep_on),
    .wake_req(wake_req), .irq(irq)
  );

  nvmcc_array_model nvmcc_array_model_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .op_start(op_start), .lag(lag),
    .op_done(op_done)
  );

  // counted mid-cycle so the main sequence never races the edge
  always @(negedge clk_sys) begin
    if (op_start === 1'b1) begin
      n_starts++;
      last_code = op_code;
      last_addr = op_addr;
    end
    if (op_done === 1'b1) begin
      n_done++;
    end
  end

  task automatic chk(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic results();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results

  // every bus task starts at an edge and ends mid-cycle
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(negedge clk_sys);
  endtask : wr

  task automatic kwr(input logic [7:0] key, input logic [7:0] d);
    wr(4'hf, key);
    wr(4'h0, d);
  endtask : kwr

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    chk("reg_rdata at index", {a, reg_rdata}, {a, exp});
  endtask : rd

  // ends just past the negedge so the start counter has already run
  task automatic st(input logic ee, input logic [23:0] a);
    @(posedge clk_sys);
    store_to_eeprom <= ee;
    store_addr <= a;
    store_data <= a[15:0];
    store_req <= 1'b1;
    @(posedge clk_sys);
    store_req <= 1'b0;
    @(negedge clk_sys);
    #1;
  endtask : st

  task automatic wt(input int want);
    for (int i = 0; i < 400 && n_done < want; i++) @(posedge clk_sys);
    @(negedge clk_sys);
    if (n_done < want) begin
      n_mismatch++;
      $display("[FAIL] op_done count expected %0d seen %0d", want, n_done);
      results();
    end
  endtask : wt

  initial begin : main
    int sb;
    int nops;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    wr(4'h5, 8'hff);
    wr(4'hc, 8'hff);
    wr(4'h0, 8'h12);
    kwr(8'hd8, 8'h12);
    for (int k = 0; k < 12; k++) begin
      rd(regs[k][11:8], regs[k][7:0]);
    end
    wr(4'hf, 8'hd8);
    wr(4'h1, 8'h07);
    rd(4'h1, 8'h07);
    for (int k = 0; k < 22; k++) begin
      kwr(8'h9d, {1'b0, codes[k][6:0]});
      if (!codes[k][7]) rd(4'h0, {1'b0, codes[k][6:0]});
      rd(4'h2, {3'b000, codes[k][7], 4'h0});
      kwr(8'h9d, 8'h00);
    end
    chk("starts while arming", n_starts, 0);
    lag <= 8'd40;
    wr(4'h3, 8'h01);
    @(negedge clk_sys);
    chk("irq idle", irq, 1'b1);
    kwr(8'h9d, 8'h12);
    st(1'b1, 24'h000123);
    chk("store code", last_code, 7'h12);
    chk("store addr", last_addr, 24'h000123);
    rd(4'h2, 8'h02);
    wr(4'h4, 8'h01);
    rd(4'h4, 8'h00);
    sys_sleep <= 1'b1;
    sleep_is_idle <= 1'b1;
    kwr(8'h9d, 8'h13);
    rd(4'h2, 8'h32);
    chk("irq busy", irq, 1'b0);
    chk("asleep busy", ctrl_asleep, 1'b0);
    chk("clock kept", clk_keep_on, 1'b1);
    wt(1);
    rd(4'h4, 8'h01);
    chk("irq ready", irq, 1'b1);
    chk("asleep idle", ctrl_asleep, 1'b1);
    chk("clock off", clk_keep_on, 1'b0);
    chk("wake idle", wake_req, 1'b1);
    @(posedge clk_sys);
    sleep_is_idle <= 1'b0;
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk("wake deep", wake_req, 1'b0);
    st(1'b1, 24'h000124);
    chk("starts in collision", n_starts, 1);
    rd(4'h0, 8'h12);
    wr(4'h2, 8'h00);
    st(1'b1, 24'h000125);
    chk("starts after clear", n_starts, 2);
    wt(2);
    sys_sleep <= 1'b0;
    kwr(8'h9d, 8'h00);
    kwr(8'h9d, 8'h30);
    rd(4'h2, 8'h02);
    chk("stall in erase", cpu_stall, 1'b1);
    wt(3);
    chk("erase code", last_code, 7'h30);
    @(negedge clk_sys);
    chk("stall after", cpu_stall, 1'b0);
    st(1'b1, 24'h000126);
    chk("no store on erase code", n_starts, 3);
    kwr(8'h9d, 8'h00);
    kwr(8'h9d, 8'h08);
    st(1'b0, 24'h000200);
    chk("flash code", last_code, 7'h08);
    rd(4'h2, 8'h01);
    wt(4);
    // short lag keeps the three chip erases cheap
    lag <= 8'd6;
    reg_from_debug <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      keep_eeprom_fuse <= chip[k][1];
      device_locked <= chip[k][0];
      repeat (3) @(posedge clk_sys);
      sb = n_starts;
      nops = (chip[k] == 2'b10) ? 1 : 2;
      kwr(8'h9d, 8'h00);
      kwr(8'h9d, 8'h20);
      @(negedge clk_sys);
      chk("brown-out kept", bod_keep_on, 1'b1);
      wt(n_done + nops);
      repeat (4) @(negedge clk_sys);
      chk("chip ops", n_starts - sb, nops);
      chk("chip last", last_code, nops == 2 ? 7'h30 : 7'h20);
      rd(4'h2, 8'h00);
    end
    kwr(8'h9d, 8'h00);
    kwr(8'h9d, 8'h30);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    sb = n_starts;
    repeat (3) @(posedge clk_sys);
    rd(4'h2, 8'h00);
    rd(4'h0, 8'h00);
    chk("stall after reset", cpu_stall, 1'b0);
    repeat (20) @(negedge clk_sys);
    chk("no restart", n_starts, sb);
    results();
  end : main
endmodule : tb_nvm_command_controller
`default_nettype wire
